// ===== inc/tog_pkg.sv
// shared constants for the thermal overload guard
`default_nettype none

package tog_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [15:0] OFS_PEAK     = 16'h2031;
  localparam logic [15:0] OFS_RATED    = 16'h2B01;
  localparam logic [15:0] OFS_DUR      = 16'h2B02;
  localparam logic [15:0] OFS_THR      = 16'h2B03;
  localparam logic [15:0] OFS_ACC      = 16'h2B04;
  localparam logic [15:0] OFS_GRANT    = 16'h2B05;
  localparam logic [15:0] OFS_STATE    = 16'h2B06;
  localparam logic [15:0] OFS_GUARD_EN = 16'h2B07;
  localparam logic [15:0] OFS_SUBMODE  = 16'h3202;

  // field positions
  localparam int unsigned SUBMODE_CLOSED_BIT = 0;
  localparam int unsigned GUARD_EN_BIT       = 0;

  // reset values
  localparam logic [31:0] RST_PEAK     = 32'h0000_0000;
  localparam logic [31:0] RST_RATED    = 32'h0000_0000;
  localparam logic [31:0] RST_DUR      = 32'h0000_0000;
  localparam logic        RST_CLOSED   = 1'b0;
  localparam logic        RST_GUARD_EN = 1'b0;

  // guard state as read back by software
  localparam logic [31:0] GUARD_STATE_OFF = 32'h0000_0000;
  localparam logic [31:0] GUARD_STATE_ON  = 32'h0000_0001;

  // timing: accumulation step is one control period
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // guard modes, one-hot
  typedef enum logic [4:0] {
    TOG_OFF    = 5'b00001,  // guard disabled, peak granted
    TOG_CAP    = 5'b00010,  // open loop, capped at rated
    TOG_BYPASS = 5'b00100,  // closed loop, settings unusable
    TOG_ARMED  = 5'b01000,  // active, below threshold
    TOG_LIMIT  = 5'b10000   // active, threshold reached
  } tog_mode_e;

endpackage

`default_nettype wire

// ===== src/tog_tick.sv
// divider making the one-cycle control period pulse
`default_nettype none

module tog_tick
  import tog_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES  // clocks per pulse
) (
  input  wire logic clk,
  input  wire logic nrst,
  output var  logic tick
);

  localparam int unsigned CW = $clog2(PERIOD);

  if (PERIOD < 2) begin : g_bad_period
    $error("tog_tick: PERIOD must be at least 2");
  end

  // whole state of the divider
  typedef struct packed {
    logic [CW-1:0] cnt;  // cycles since last pulse
    logic          tick; // pulse register
  } tog_tick_s;

  tog_tick_s q;
  tog_tick_s d;

  // count to PERIOD-1, then pulse once and wrap
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == CW'(PERIOD - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  // registers, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

`default_nettype wire

// ===== src/tog_mult.sv
// registered unsigned multiplier for the threshold product
`default_nettype none

module tog_mult #(
  parameter int unsigned A_W = 32,  // width of first factor
  parameter int unsigned B_W = 16   // width of second factor
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [A_W-1:0]     a,
  input  wire logic [B_W-1:0]     b,
  output var  logic [A_W+B_W-1:0] p
);

  localparam int unsigned P_W = A_W + B_W;

  if (A_W < 1 || B_W < 1) begin : g_bad_width
    $error("tog_mult: factor widths must be positive");
  end

  // whole state: the product register
  typedef struct packed {
    logic [P_W-1:0] p;
  } tog_mult_s;

  tog_mult_s q;
  tog_mult_s d;

  // full-width product, one cycle of latency
  always_comb begin
    d   = q;
    d.p = P_W'(a) * P_W'(b);
  end

  // registers, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign p = q.p;

endmodule

`default_nettype wire

// ===== src/tog_guard.sv
// thermal overload guard: settings, heat accumulator, current clamp
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none

module tog_guard
  import tog_pkg::*;
#(
  parameter int unsigned CUR_W       = 16,          // current width, mA
  parameter int unsigned DUR_W       = 16,          // duration width, ms
  parameter int unsigned TICK_PERIOD = TICK_CYCLES  // clocks per step
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [CUR_W-1:0]  motor_current,
  output var  logic [DATA_W-1:0] rd_data,
  output var  logic [CUR_W-1:0]  granted_current_limit,
  output var  logic              guard_active
);

  localparam int unsigned SQ_W  = 2 * CUR_W;      // squared current
  localparam int unsigned LIM_W = SQ_W + DUR_W;   // threshold, heat
  localparam int unsigned SH_W  = LIM_W - DATA_W; // bits dropped on read

  // refuse widths the read scaling cannot serve
  if (CUR_W < 1 || CUR_W > 32 || DUR_W < 1 || DUR_W > 32
      || LIM_W < DATA_W || TICK_PERIOD < 2) begin : g_bad_param
    $error("tog_guard: unsupported parameter values");
  end

  // whole state of the guard
  typedef struct packed {
    logic [CUR_W-1:0]  peak;   // peak current setting
    logic [CUR_W-1:0]  rated;  // rated current setting
    logic [DUR_W-1:0]  dur;    // peak duration setting
    logic              closed; // closed loop selected
    logic              en;     // guard enabled
    logic [LIM_W-1:0]  acc;    // heat accumulator
    tog_mode_e         mode;   // guard mode
    logic              active; // guard active flag
    logic [CUR_W-1:0]  grant;  // granted current
    logic [DATA_W-1:0] rdata;  // read answer
  } tog_core_s;

  tog_core_s q;
  tog_core_s d;

  logic              tick;     // one pulse per control period
  logic [SQ_W-1:0]   sq_gap;   // peak squared minus rated squared
  logic [LIM_W-1:0]  lim;      // threshold, one cycle behind settings
  logic [SQ_W-1:0]   sq_cur;   // measured current squared
  logic [SQ_W-1:0]   sq_rated; // rated current squared
  logic [LIM_W:0]    sum;      // accumulator plus step, one spare bit
  logic [LIM_W-1:0]  dec;      // decay step

  // squares of currents, used for measured, rated and peak
  function automatic logic [SQ_W-1:0] sq(input logic [CUR_W-1:0] v);
    return SQ_W'(v) * SQ_W'(v);
  endfunction

  // top bits of a wide value, as software sees it
  function automatic logic [DATA_W-1:0] rd_scale(input logic [LIM_W-1:0] v);
    return v[LIM_W-1 -: DATA_W];
  endfunction

  // guard live in either of the two active modes
  function automatic logic is_active(input tog_mode_e m);
    return (m == TOG_ARMED) || (m == TOG_LIMIT);
  endfunction

  // control period pulse
  tog_tick #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  // threshold = (peak^2 - rated^2) * duration; zero when unusable
  assign sq_gap = (q.peak > q.rated) ? (sq(q.peak) - sq(q.rated)) : '0;

  tog_mult #(
    .A_W (SQ_W),
    .B_W (DUR_W)
  ) u_mult (
    .clk  (clk),
    .nrst (nrst),
    .a    (sq_gap),
    .b    (q.dur),
    .p    (lim)
  );

  // next state: register port, accumulator, mode, grant
  always_comb begin
    d        = q;
    d.rdata  = '0;
    sq_cur   = sq(motor_current);
    sq_rated = sq(q.rated);
    sum      = '0;
    dec      = '0;

    // register writes; unmapped addresses are ignored
    if (wr_en) begin
      case (addr)
        OFS_PEAK:     d.peak   = wr_data[CUR_W-1:0];
        OFS_RATED:    d.rated  = wr_data[CUR_W-1:0];
        OFS_DUR:      d.dur    = wr_data[DUR_W-1:0];
        OFS_SUBMODE:  d.closed = wr_data[SUBMODE_CLOSED_BIT];
        OFS_GUARD_EN: d.en     = wr_data[GUARD_EN_BIT];
        default: ;
      endcase
    end

    // register reads; answer stands in the next cycle only
    if (rd_en) begin
      case (addr)
        OFS_PEAK:     d.rdata = DATA_W'(q.peak);
        OFS_RATED:    d.rdata = DATA_W'(q.rated);
        OFS_DUR:      d.rdata = DATA_W'(q.dur);
        OFS_THR:      d.rdata = rd_scale(lim);
        OFS_ACC:      d.rdata = rd_scale(q.acc);
        OFS_GRANT:    d.rdata = DATA_W'(q.grant);
        OFS_STATE:    d.rdata = q.active ? GUARD_STATE_ON
                                         : GUARD_STATE_OFF;
        OFS_SUBMODE:  d.rdata = DATA_W'(q.closed);
        OFS_GUARD_EN: d.rdata = DATA_W'(q.en);
        default:      d.rdata = '0;
      endcase
    end

    // heat accumulates once per control period while active
    if (is_active(q.mode)) begin
      if (tick) begin
        if (sq_cur > sq_rated) begin
          // step grows with the square, so peak fills it soonest
          sum = {1'b0, q.acc} + (LIM_W + 1)'(sq_cur - sq_rated);
          // clamp at threshold so decay starts from a known level
          d.acc = (sum > {1'b0, lim}) ? lim : sum[LIM_W-1:0];
        end else if (sq_cur < sq_rated) begin
          dec   = LIM_W'(sq_rated - sq_cur);
          d.acc = (q.acc > dec) ? (q.acc - dec) : '0;
        end
      end
    end else begin
      // leaving the active modes forgets old heat
      d.acc = '0;
    end

    // mode from settings; compare uses the updated heat at once
    if (!q.en) begin
      d.mode = TOG_OFF;
    end else if (!q.closed) begin
      d.mode = TOG_CAP;
    end else if (q.peak <= q.rated || q.dur == '0) begin
      d.mode = TOG_BYPASS;
    end else if (d.acc >= lim) begin
      d.mode = TOG_LIMIT;
    end else begin
      d.mode = TOG_ARMED;
    end
    d.active = is_active(d.mode);

    // granted current follows the new mode in the same cycle
    case (d.mode)
      TOG_OFF:    d.grant = q.peak;
      TOG_BYPASS: d.grant = q.peak;
      TOG_ARMED:  d.grant = q.peak;
      TOG_LIMIT:  d.grant = q.rated;
      // never grant more than either setting in open loop
      TOG_CAP:    d.grant = (q.peak < q.rated) ? q.peak : q.rated;
      default:    d.grant = q.rated;
    endcase
  end

  // registers, synchronous reset to the package defaults
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q        <= '0;
      q.peak   <= RST_PEAK[CUR_W-1:0];
      q.rated  <= RST_RATED[CUR_W-1:0];
      q.dur    <= RST_DUR[DUR_W-1:0];
      q.closed <= RST_CLOSED;
      q.en     <= RST_GUARD_EN;
      q.mode   <= TOG_OFF;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rd_data               = q.rdata;
  assign granted_current_limit = q.grant;
  assign guard_active          = q.active;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // peak setting follows a write
  a_peak_write: assert property (
    wr_en && addr == OFS_PEAK |=> q.peak == $past(wr_data[CUR_W-1:0])
  ) else $error("peak setting not stored");

  // rated setting follows a write
  a_rated_write: assert property (
    wr_en && addr == OFS_RATED |=> q.rated == $past(wr_data[CUR_W-1:0])
  ) else $error("rated setting not stored");

  // duration setting follows a write
  a_dur_write: assert property (
    wr_en && addr == OFS_DUR |=> q.dur == $past(wr_data[DUR_W-1:0])
  ) else $error("duration setting not stored");

  // threshold read answers with the scaled limit
  a_thr_read: assert property (
    rd_en && addr == OFS_THR |=> rd_data == rd_scale($past(lim))
  ) else $error("threshold read wrong");

  // heat read answers with the accumulator
  a_acc_read: assert property (
    rd_en && addr == OFS_ACC |=> rd_data == rd_scale($past(q.acc))
  ) else $error("accumulator read wrong");

  // grant read answers with the output value
  a_grant_read: assert property (
    rd_en && addr == OFS_GRANT
      |=> rd_data == DATA_W'($past(granted_current_limit))
  ) else $error("grant read wrong");

  // state flag tracks the activation conditions
  a_state_cond: assert property (
    !guard_active |-> !$past(q.en) || !$past(q.closed)
                      || $past(q.peak) <= $past(q.rated) || $past(q.dur) == '0
  ) else $error("guard inactive without cause");

  // guard never active when open loop is selected
  a_open_idle: assert property (
    !q.closed && $stable(q.closed) |=> !guard_active
  ) else $error("guard active in open loop");

  // peak not above rated keeps the guard off and grants peak
  a_bypass_peak: assert property (
    q.en && q.closed && q.peak <= q.rated && $stable(q.peak)
      |=> !guard_active && granted_current_limit == $past(q.peak)
  ) else $error("bypass did not grant peak");

  // threshold product one cycle after settings settle
  a_thr_value: assert property (
    $stable(q.peak) && $stable(q.rated) && $stable(q.dur)
      |-> lim == LIM_W'(sq_gap) * LIM_W'(q.dur)
  ) else $error("threshold value wrong");

  // at the threshold the grant drops to rated at once
  a_limit_rated: assert property (
    q.mode == TOG_LIMIT |-> granted_current_limit == $past(q.rated)
  ) else $error("limit mode not at rated");

  // heat only moves on a control pulse
  a_acc_hold: assert property (
    guard_active && !tick ##1 guard_active |-> $stable(q.acc)
  ) else $error("heat moved without a pulse");

  // overcurrent below threshold raises the heat
  a_acc_grow: assert property (
    is_active(q.mode) && tick && motor_current > q.rated && q.acc < lim
      && $stable(lim) ##1 is_active(q.mode)
      |-> q.acc > $past(q.acc)
  ) else $error("heat did not grow");

  // open loop with guard on caps the grant
  a_open_cap: assert property (
    q.en && !q.closed && $stable(q.rated) && $stable(q.peak)
      |=> granted_current_limit <= $past(q.rated)
  ) else $error("open loop grant above rated");

  // undercurrent lowers nonzero heat
  a_acc_decay: assert property (
    is_active(q.mode) && tick && motor_current < q.rated && q.acc != '0
      ##1 is_active(q.mode) |-> q.acc < $past(q.acc)
  ) else $error("heat did not decay");

  // main scenarios
  c_reach_limit: cover property (q.mode == TOG_ARMED ##1 q.mode == TOG_LIMIT);
  c_recover:     cover property (q.mode == TOG_LIMIT ##1 q.mode == TOG_ARMED);
  c_open_cap:    cover property (q.mode == TOG_CAP && q.peak > q.rated);
  c_state_read:  cover property (rd_en && addr == OFS_STATE && guard_active);

endmodule

`default_nettype wire

// ===== test/tog_motor_loop.sv
// behavioural motor current loop standing behind the guard's clamp
`default_nettype none

module tog_motor_loop #(
  parameter int unsigned CUR_W = 16  // current width, mA
) (
  input  wire logic [CUR_W-1:0] demand,                 // current the load asks for
  input  wire logic [CUR_W-1:0] granted_current_limit,  // clamp from the guard
  output var  logic [CUR_W-1:0] motor_current           // measured current fed back
);
  timeunit 1ns;
  timeprecision 1ps;

  // ideal loop: reaches demand at once but never passes the clamp,
  // so a limited motor settles exactly at rated and heat stops rising
  always_comb begin
    if (demand > granted_current_limit) begin
      motor_current = granted_current_limit;  // clamped
    end else begin
      motor_current = demand;                 // free running
    end
  end

endmodule

`default_nettype wire

// ===== test/tog_guard_tb.sv
// self-checking bench for the thermal overload guard
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
      mismatches++; \
    end \
  end

module tog_guard_tb
  import tog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TP = 8;  // short control period keeps the run brief

  logic        clk = 1'b0;              // 100 MHz
  logic        nrst = 1'b0;             // synchronous, active low
  logic [15:0] addr = 16'h0000;         // register address
  logic [31:0] wr_data = 32'h0000_0000; // write data
  logic        wr_en = 1'b0;            // write strobe
  logic        rd_en = 1'b0;            // read strobe
  logic [15:0] demand = 16'h0000;       // load demand into the motor model
  logic [15:0] motor_current;           // model feedback
  logic [31:0] rd_data;                 // read answer
  logic [15:0] grant;                   // granted current limit
  logic        guard_active;            // guard status pin
  logic [31:0] rv;                      // last read value
  int          n;                       // cycle count of a wait
  int          mismatches = 0;
  int          check_count = 0;

  tog_guard #(.TICK_PERIOD(TP)) u_tog_guard (
    .clk                   (clk),
    .nrst                  (nrst),
    .addr                  (addr),
    .wr_data               (wr_data),
    .wr_en                 (wr_en),
    .rd_en                 (rd_en),
    .motor_current         (motor_current),
    .rd_data               (rd_data),
    .granted_current_limit (grant),
    .guard_active          (guard_active)
  );

  tog_motor_loop u_tog_motor_loop (
    .demand                (demand),
    .granted_current_limit (grant),
    .motor_current         (motor_current)
  );

  // free-running clock
  always #5 clk = ~clk;

  // closing report, also reached from any exhausted wait
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // one-cycle read strobe; answer stands only in the next cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask

  // read and compare in one call
  task automatic chk_rd(input logic [15:0] a, input logic [31:0] e, input string nm);
    rd(a, rv);
    `CHK(nm, e, rv)
  endtask

  // let settings settle through the multiplier stage, end mid-cycle
  // so that pin checks never race the edge that updates them
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // wait at falling edges for the grant pin, bounded
  task automatic wait_grant(input logic [15:0] e, input int lim);
    n = 0;
    while (grant !== e) begin
      if (n >= lim) begin
        mismatches++;
        give_verdict();
      end
      @(negedge clk);
      n++;
    end
  endtask

  // poll the heat value until the first step has landed, bounded
  task automatic first_step(input logic [31:0] e, input string nm);
    int k;
    k = 0;
    rv = 32'h0000_0000;
    while (rv === 32'h0000_0000) begin
      if (k >= 3 * TP) begin
        mismatches++;
        give_verdict();
      end
      rd(OFS_ACC, rv);
      k++;
    end
    `CHK(nm, e, rv)
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    // reset values, unmapped place
    `CHK("grant rst", 16'h0000, grant)
    `CHK("active rst", 1'b0, guard_active)
    chk_rd(OFS_PEAK, 32'h0000_0000, "peak rst");
    chk_rd(OFS_RATED, 32'h0000_0000, "rated rst");
    chk_rd(OFS_DUR, 32'h0000_0000, "dur rst");
    chk_rd(OFS_THR, 32'h0000_0000, "thr rst");
    chk_rd(OFS_ACC, 32'h0000_0000, "acc rst");
    chk_rd(OFS_STATE, 32'h0000_0000, "state rst");
    chk_rd(16'h1234, 32'h0000_0000, "unmapped");
    // settings keep the low 16 bits only
    wr(OFS_PEAK, 32'hFFFF_03E8);
    wr(OFS_RATED, 32'h0000_01F4);
    wr(OFS_DUR, 32'h0000_0004);
    settle();
    chk_rd(OFS_PEAK, 32'h0000_03E8, "peak");
    chk_rd(OFS_RATED, 32'h0000_01F4, "rated");
    chk_rd(OFS_DUR, 32'h0000_0004, "dur");
    // (1000^2-500^2)*4 = 3000000, read shifted by 16
    chk_rd(OFS_THR, 32'h0000_002D, "thr");
    wr(OFS_THR, 32'h0000_1234);
    chk_rd(OFS_THR, 32'h0000_002D, "thr ro");
    // guard off grants peak
    `CHK("grant off", 16'h03E8, grant)
    wr(OFS_GUARD_EN, 32'h0000_0001);
    settle();
    // open loop caps at rated, status stays off
    `CHK("grant cap", 16'h01F4, grant)
    `CHK("active cap", 1'b0, guard_active)
    @(posedge clk) demand <= 16'h03E8;
    wr(OFS_SUBMODE, 32'h0000_0001);
    settle();
    `CHK("active on", 1'b1, guard_active)
    chk_rd(OFS_STATE, 32'h0000_0001, "state on");
    // peak current: 750000 per step, 11 once shifted
    first_step(32'h0000_000B, "acc step pk");
    wait_grant(16'h01F4, 4 * TP);
    // three more steps reach the threshold
    `CHK("limit delay", 1'b1, (n >= 3 * TP - 4) && (n <= 3 * TP))
    chk_rd(OFS_ACC, 32'h0000_002D, "acc at lim");
    chk_rd(OFS_GRANT, 32'h0000_01F4, "grant reg");
    // read answer stands one cycle only, then returns to zero
    @(negedge clk);
    `CHK("rd idle", 32'h0000_0000, rd_data)
    repeat (2 * TP) @(negedge clk);
    `CHK("grant held", 16'h01F4, grant)
    // load drops: one decay step restores peak
    @(posedge clk) demand <= 16'h0000;
    wait_grant(16'h03E8, TP + 3);
    chk_rd(OFS_ACC, 32'h0000_0029, "acc decay");
    // mode switches read back as written
    chk_rd(OFS_SUBMODE, 32'h0000_0001, "submode");
    chk_rd(OFS_GUARD_EN, 32'h0000_0001, "guard en");
    // smaller overcurrent builds heat slower: 312500 per step
    wr(OFS_SUBMODE, 32'h0000_0000);
    demand <= 16'h02EE;
    settle();
    wr(OFS_SUBMODE, 32'h0000_0001);
    first_step(32'h0000_0004, "acc step mid");
    // peak not above rated keeps the guard off
    wr(OFS_PEAK, 32'h0000_0190);
    settle();
    `CHK("active pk lo", 1'b0, guard_active)
    `CHK("grant pk lo", 16'h0190, grant)
    wr(OFS_PEAK, 32'h0000_03E8);
    wr(OFS_DUR, 32'h0000_0000);
    settle();
    `CHK("active dur0", 1'b0, guard_active)
    chk_rd(OFS_THR, 32'h0000_0000, "thr dur0");
    chk_rd(OFS_STATE, 32'h0000_0000, "state off");
    give_verdict();
  end

endmodule

`undef CHK

`default_nettype wire
